// file: core/mtc_pkg.sv
// constants, types and helpers for the measurement trigger controller
//Contract
//- internal mode restarts measurement after each cycle
//- key press starts one single measurement
//- rear or handler pulse starts measurement
//- each bus trigger command gives one cycle
//- triggers during a running cycle are discarded
//- accept only after done output went low
//- rear input edge chosen by polarity setting
//- polarity leaves handler trigger line sense fixed
//- frequency shift clamped to minus two..plus two
//- compute phase 0.7ms without status update
//- auto range adds ranging interval
//- display off shortens compute phase
package mtc_pkg;

   localparam int unsigned CLK_MHZ             = 200;
   // phase times in microseconds; compute is 1 ms / 0.7 ms
   localparam int unsigned COMPUTE_STAT_ON_US  = 1000;
   localparam int unsigned COMPUTE_STAT_OFF_US = 700;
   localparam int unsigned DISPLAY_SAVE_US     = 100;
   localparam int unsigned RANGE_US            = 500;
   localparam int unsigned ANALOG_US           = 1000;
   localparam int unsigned COMPUTE_ON_CYC      = COMPUTE_STAT_ON_US * CLK_MHZ;
   localparam int unsigned COMPUTE_OFF_CYC     = COMPUTE_STAT_OFF_US * CLK_MHZ;
   localparam int unsigned DISPLAY_SAVE_CYC    = DISPLAY_SAVE_US * CLK_MHZ;
   localparam int unsigned RANGE_CYC           = RANGE_US * CLK_MHZ;
   localparam int unsigned ANALOG_CYC          = ANALOG_US * CLK_MHZ;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // control field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_EDGE_BIT  = 2;
   localparam int unsigned CTRL_STAT_BIT  = 3;
   localparam int unsigned CTRL_DISP_BIT  = 4;
   localparam int unsigned CTRL_RANGE_BIT = 5;
   localparam int unsigned CTRL_SHIFT_LSB = 8;
   localparam int unsigned CMD_TRIG_BIT   = 0;

   // status field positions
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned STAT_DONE_BIT    = 1;
   localparam int unsigned STAT_PHASE_LSB   = 2;
   localparam int unsigned STAT_DISCARD_LSB = 8;
   localparam int unsigned STAT_COUNT_LSB   = 16;

   localparam logic signed [7:0] SHIFT_MAX = 8'sh02;
   localparam logic signed [7:0] SHIFT_MIN = -8'sh02;

   typedef enum logic [1:0] {
      MTC_MODE_INT,
      MTC_MODE_KEY,
      MTC_MODE_EXT,
      MTC_MODE_BUS
   } mtc_mode_t;

   localparam logic RISING_EDGE_OPTION  = 1'b0;
   localparam logic FALLING_EDGE_OPTION = 1'b1;

   typedef struct packed {
      logic [7:0] freq_shift;
      logic       auto_range;
      logic       display_en;
      logic       status_update_en;
      logic       rear_trigger_edge_select;
      mtc_mode_t  mode;
   } mtc_cfg_t;

   localparam mtc_cfg_t CFG_RESET = '{
      freq_shift: 8'h00,
      auto_range: 1'b1,
      display_en: 1'b1,
      status_update_en: 1'b1,
      rear_trigger_edge_select: RISING_EDGE_OPTION,
      mode: MTC_MODE_INT
   };

   function automatic logic [7:0] mtc_clamp_shift(input logic [7:0] v);
      logic signed [7:0] s;
      s = $signed(v);
      if (s > SHIFT_MAX) begin
         return SHIFT_MAX;
      end else if (s < SHIFT_MIN) begin
         return SHIFT_MIN;
      end
      return v;
   endfunction : mtc_clamp_shift

endpackage : mtc_pkg

// file: core/mtc_edge_det.sv
// single-bit rise and fall detector for synchronous inputs
`timescale 1ns/1ps
module mtc_edge_det #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic sig,
   output logic      rise,
   output logic      fall
);
   logic prev_r;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_r <= IDLE_LEVEL;
      end else begin
         prev_r <= sig;
      end
   end

   assign rise = sig & ~prev_r;
   assign fall = ~sig & prev_r;

endmodule : mtc_edge_det

// file: core/mtc_trigger_ctrl.sv
// measurement trigger controller with classic wishbone register slave
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mtc_trigger_ctrl #(
   parameter int unsigned P_COMPUTE_ON_CYC   = mtc_pkg::COMPUTE_ON_CYC,
   parameter int unsigned P_COMPUTE_OFF_CYC  = mtc_pkg::COMPUTE_OFF_CYC,
   parameter int unsigned P_DISPLAY_SAVE_CYC = mtc_pkg::DISPLAY_SAVE_CYC,
   parameter int unsigned P_RANGE_CYC        = mtc_pkg::RANGE_CYC,
   parameter int unsigned P_ANALOG_CYC       = mtc_pkg::ANALOG_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        key_press,
   input  wire logic        rear_trigger_in,
   input  wire logic        handler_trigger_in,
   output logic             measurement_done_n,
   output logic             meas_start,
   output logic             ranging,
   output logic             measuring,
   output logic             computing,
   output logic      [7:0]  freq_shift_pct
);
   import mtc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RANGE,
      ST_MEASURE,
      ST_COMPUTE
   } mtc_state_t;

   mtc_cfg_t   cfg_r;
   mtc_state_t state_r;
   logic [31:0] cnt_r;
   logic        done_n_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic        start_r;
   logic [7:0]  discard_r;
   logic [15:0] complete_r;

   logic        wr_en;
   logic        bus_trig;
   logic        key_rise;
   logic        rear_rise;
   logic        rear_fall;
   logic        rear_hit;
   logic        hnd_rise;
   logic        trig_req;
   logic        trig_accept;
   logic [31:0] comp_len;
   logic [31:0] rd_mux;

   // edge detectors
   mtc_edge_det #(.IDLE_LEVEL(1'b0)) u_key (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .sig      (key_press),
      .rise     (key_rise),
      .fall     ()
   );

   mtc_edge_det #(.IDLE_LEVEL(1'b0)) u_rear (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .sig      (rear_trigger_in),
      .rise     (rear_rise),
      .fall     (rear_fall)
   );

   mtc_edge_det #(.IDLE_LEVEL(1'b0)) u_hnd (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .sig      (handler_trigger_in),
      .rise     (hnd_rise),
      .fall     ()
   );

   // rear edge follows polarity; handler line always rising
   assign rear_hit = (cfg_r.rear_trigger_edge_select == FALLING_EDGE_OPTION) ?
                     rear_fall : rear_rise;

   // wishbone slave: ack one cycle after request, write at ack edge
   assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
   assign bus_trig = wr_en & (wb_adr_i == ADDR_CMD) & wb_sel_i[0] & wb_dat_i[CMD_TRIG_BIT];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         ADDR_CTRL: begin
            rd_mux[CTRL_MODE_LSB +: 2]     = cfg_r.mode;
            rd_mux[CTRL_EDGE_BIT]          = cfg_r.rear_trigger_edge_select;
            rd_mux[CTRL_STAT_BIT]          = cfg_r.status_update_en;
            rd_mux[CTRL_DISP_BIT]          = cfg_r.display_en;
            rd_mux[CTRL_RANGE_BIT]         = cfg_r.auto_range;
            rd_mux[CTRL_SHIFT_LSB +: 8]    = cfg_r.freq_shift;
         end
         ADDR_STATUS: begin
            rd_mux[STAT_BUSY_BIT]          = (state_r != ST_IDLE);
            rd_mux[STAT_DONE_BIT]          = done_n_r;
            rd_mux[STAT_PHASE_LSB +: 3]    = state_r;
            rd_mux[STAT_DISCARD_LSB +: 8]  = discard_r;
            rd_mux[STAT_COUNT_LSB +: 16]   = complete_r;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r) begin
         rdata_r <= rd_mux;
      end
   end

   assign wb_dat_o = rdata_r;
   assign wb_ack_o = ack_r;

   // configuration register with byte lanes
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= CFG_RESET;
      end else if (wr_en && wb_adr_i == ADDR_CTRL) begin
         if (wb_sel_i[0]) begin
            cfg_r.mode                     <= mtc_mode_t'(wb_dat_i[CTRL_MODE_LSB +: 2]);
            cfg_r.rear_trigger_edge_select <= wb_dat_i[CTRL_EDGE_BIT];
            cfg_r.status_update_en         <= wb_dat_i[CTRL_STAT_BIT];
            cfg_r.display_en               <= wb_dat_i[CTRL_DISP_BIT];
            cfg_r.auto_range               <= wb_dat_i[CTRL_RANGE_BIT];
         end
         if (wb_sel_i[1]) begin
            cfg_r.freq_shift <= mtc_clamp_shift(wb_dat_i[CTRL_SHIFT_LSB +: 8]);
         end
      end
   end

   assign freq_shift_pct = cfg_r.freq_shift;

   // trigger source selection
   always_comb begin
      case (cfg_r.mode)
         MTC_MODE_INT: trig_req = 1'b1;
         MTC_MODE_KEY: trig_req = key_rise;
         MTC_MODE_EXT: trig_req = rear_hit | hnd_rise;
         MTC_MODE_BUS: trig_req = bus_trig;
         default:      trig_req = 1'b0;
      endcase
   end

   // only an idle controller with done low takes a trigger
   assign trig_accept = trig_req & (state_r == ST_IDLE) & ~done_n_r;

   // compute length from status update and display settings
   always_comb begin
      comp_len = cfg_r.status_update_en ? 32'(P_COMPUTE_ON_CYC) :
                                          32'(P_COMPUTE_OFF_CYC);
      if (!cfg_r.display_en) begin
         comp_len = comp_len - 32'(P_DISPLAY_SAVE_CYC);
      end
   end

   // measurement cycle sequencer
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r  <= ST_IDLE;
         cnt_r    <= 32'h0000_0000;
         done_n_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (trig_accept) begin
                  done_n_r <= 1'b1;
                  if (cfg_r.auto_range) begin
                     state_r <= ST_RANGE;
                     cnt_r   <= 32'(P_RANGE_CYC) - 32'h1;
                  end else begin
                     state_r <= ST_MEASURE;
                     cnt_r   <= 32'(P_ANALOG_CYC) - 32'h1;
                  end
               end
            end
            ST_RANGE: begin
               if (cnt_r == 32'h0) begin
                  state_r <= ST_MEASURE;
                  cnt_r   <= 32'(P_ANALOG_CYC) - 32'h1;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            ST_MEASURE: begin
               if (cnt_r == 32'h0) begin
                  state_r <= ST_COMPUTE;
                  cnt_r   <= comp_len - 32'h1;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            ST_COMPUTE: begin
               if (cnt_r == 32'h0) begin
                  state_r  <= ST_IDLE;
                  done_n_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            default: begin
               state_r  <= ST_IDLE;
               done_n_r <= 1'b0;
            end
         endcase
      end
   end

   assign measurement_done_n = done_n_r;
   assign ranging            = (state_r == ST_RANGE);
   assign measuring          = (state_r == ST_MEASURE);
   assign computing          = (state_r == ST_COMPUTE);

   // start pulse and statistics
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         start_r <= 1'b0;
      end else begin
         start_r <= trig_accept;
      end
   end

   assign meas_start = start_r;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         discard_r <= 8'h00;
      end else if (trig_req && !trig_accept && cfg_r.mode != MTC_MODE_INT &&
                   discard_r != 8'hFF) begin
         discard_r <= discard_r + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         complete_r <= 16'h0000;
      end else if (state_r == ST_COMPUTE && cnt_r == 32'h0) begin
         complete_r <= complete_r + 16'h0001;
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_int_restart: assert property (
      (state_r == ST_IDLE && !done_n_r && cfg_r.mode == MTC_MODE_INT) |=>
      (state_r != ST_IDLE) && meas_start)
      else $error("internal mode did not restart");

   a_key_start: assert property (
      (state_r == ST_IDLE && !done_n_r && cfg_r.mode == MTC_MODE_KEY && key_rise) |=>
      measurement_done_n ##0 meas_start)
      else $error("key press did not start measurement");

   a_ext_start: assert property (
      (state_r == ST_IDLE && !done_n_r && cfg_r.mode == MTC_MODE_EXT && rear_hit) |=>
      (state_r != ST_IDLE))
      else $error("rear trigger did not start measurement");

   a_bus_once: assert property (
      (state_r == ST_IDLE && !done_n_r && cfg_r.mode == MTC_MODE_BUS && bus_trig) |=>
      meas_start ##1 !meas_start)
      else $error("bus trigger did not give one cycle");

   a_busy_ignore: assert property (
      (state_r != ST_IDLE) |-> !trig_accept ##1 !meas_start)
      else $error("trigger taken during measurement");

   a_done_gate: assert property (
      meas_start |-> $past(measurement_done_n == 1'b0))
      else $error("trigger accepted with done high");

   a_rear_edge: assert property (
      (state_r == ST_IDLE && !done_n_r && cfg_r.mode == MTC_MODE_EXT && !hnd_rise &&
       cfg_r.rear_trigger_edge_select == RISING_EDGE_OPTION && rear_fall) |=>
      (state_r == ST_IDLE))
      else $error("wrong rear edge started measurement");

   a_hnd_fixed: assert property (
      (state_r == ST_IDLE && !done_n_r && cfg_r.mode == MTC_MODE_EXT && hnd_rise) |=>
      (state_r != ST_IDLE))
      else $error("handler trigger sense changed");

   a_shift_clamp: assert property (
      ($signed(freq_shift_pct) <= SHIFT_MAX) && ($signed(freq_shift_pct) >= SHIFT_MIN))
      else $error("frequency shift outside limits");

   a_compute_fast: assert property (
      (state_r == ST_MEASURE && cnt_r == 32'h0 && !cfg_r.status_update_en &&
       cfg_r.display_en) |=> (cnt_r == 32'(P_COMPUTE_OFF_CYC) - 32'h1))
      else $error("compute length wrong without status update");

   a_range_skip: assert property (
      (trig_accept && !cfg_r.auto_range) |=> (state_r == ST_MEASURE))
      else $error("fixed range entered ranging");

   a_display_cut: assert property (
      (state_r == ST_MEASURE && cnt_r == 32'h0 && cfg_r.status_update_en &&
       !cfg_r.display_en) |=>
      (cnt_r == 32'(P_COMPUTE_ON_CYC) - 32'(P_DISPLAY_SAVE_CYC) - 32'h1))
      else $error("display off did not shorten compute");

   a_done_busy: assert property (
      measurement_done_n == (state_r != ST_IDLE))
      else $error("done output out of step with cycle");

   c_int_cycle: cover property (
      cfg_r.mode == MTC_MODE_INT && computing ##1 !computing ##[1:3] meas_start);
   c_bus_start: cover property (bus_trig && trig_accept);
   c_discard: cover property (trig_req && state_r != ST_IDLE && cfg_r.mode == MTC_MODE_EXT);
   c_range: cover property (ranging ##1 measuring);

endmodule : mtc_trigger_ctrl

// file: sim/mtc_handler_model.sv
// handler or scanner partner driving the external trigger lines
`timescale 1ns/1ps
module mtc_handler_model (
   input  wire logic core_clk,
   output logic      rear_trigger_in,
   output logic      handler_trigger_in
);
   initial begin
      rear_trigger_in    = 1'b0;
      handler_trigger_in = 1'b0;
   end

   // step the rear line; the device picks which edge counts
   task automatic rear_level(input logic v);
      @(posedge core_clk);
      rear_trigger_in <= v;
   endtask : rear_level

   // one positive pulse on the handler line, idle low
   task automatic handler_pulse(input int width);
      @(posedge core_clk);
      handler_trigger_in <= 1'b1;
      repeat (width) @(posedge core_clk);
      handler_trigger_in <= 1'b0;
   endtask : handler_pulse
endmodule : mtc_handler_model

// file: sim/tb_measurement_trigger_control.sv
// self-checking bench for the measurement trigger controller
`timescale 1ns/1ps
module tb_measurement_trigger_control;
   import mtc_pkg::*;
   localparam int RNG = 10, ANA = 20, C_ON = 20, C_OFF = 14, C_DS = 4;
   logic        core_clk, arst_n, wb_cyc, wb_stb, wb_we, key_press;
   logic [7:0]  wb_adr, shift_pct;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic        wb_ack, done_n, meas_start, ranging, measuring, computing;
   logic        rear_trig, handler_trig;
   logic [7:0]  tbl [4] = '{8'h02, 8'h03, 8'hFE, 8'h80};
   int          failures = 0, num_checks = 0, starts = 0, sv, len, lo, ex;
   int          rng_c = 0, ana_c = 0, cmp_c = 0, r0, a0, c0, disc_exp = 0;

   mtc_trigger_ctrl #(.P_COMPUTE_ON_CYC(C_ON), .P_COMPUTE_OFF_CYC(C_OFF),
      .P_DISPLAY_SAVE_CYC(C_DS), .P_RANGE_CYC(RNG), .P_ANALOG_CYC(ANA)) DUT (
      .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .key_press(key_press),
      .rear_trigger_in(rear_trig), .handler_trigger_in(handler_trig),
      .measurement_done_n(done_n), .meas_start(meas_start), .ranging(ranging),
      .measuring(measuring), .computing(computing), .freq_shift_pct(shift_pct));

   mtc_handler_model HM (.core_clk(core_clk), .rear_trigger_in(rear_trig),
      .handler_trigger_in(handler_trig));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) if (meas_start === 1'b1) starts++;
   // phase lengths seen on the decoded phase outputs
   always @(posedge core_clk) if (ranging === 1'b1) rng_c++;
   always @(posedge core_clk) if (measuring === 1'b1) ana_c++;
   always @(posedge core_clk) if (computing === 1'b1) cmp_c++;

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: value got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_len(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         failures++;
         $display("Error at %0t: count got %h expected %h", $time, got, exp);
      end
   endtask : chk_len

   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_dat_w <= dat;
      wb_sel   <= 4'hF;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge core_clk);
   endtask : wb_xfer

   // outside triggers only between cycles
   task automatic wait_idle;
      int n;
      n = 0;
      repeat (4) @(posedge core_clk);
      while (done_n !== 1'b0 && n < 2000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 2000) failures++;
   endtask : wait_idle

   task automatic meas_len(output int l);
      int n;
      n = 0;
      while (done_n !== 1'b1 && n < 1000) begin
         @(posedge core_clk);
         n++;
      end
      l = 0;
      while (done_n === 1'b1 && l < 1000) begin
         @(posedge core_clk);
         l++;
      end
   endtask : meas_len

   task automatic key_twice;
      key_press <= 1'b1;
      repeat (3) @(posedge core_clk);
      key_press <= 1'b0;
      repeat (3) @(posedge core_clk);
      key_press <= 1'b1;
      repeat (3) @(posedge core_clk);
      key_press <= 1'b0;
   endtask : key_twice

   function automatic int exp_len(input bit ar, input bit st, input bit dp);
      return (ar ? RNG : 0) + ANA + (st ? C_ON : C_OFF) - (dp ? 0 : C_DS);
   endfunction : exp_len

   function automatic logic [31:0] ctrl_word(input logic [1:0] md, input logic eg,
      input logic st, input logic dp, input logic ar, input logic [7:0] sh);
      return {16'h0000, sh, 2'b00, ar, dp, st, eg, md};
   endfunction : ctrl_word

   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      end_sim();
   end

   initial begin
      logic [7:0] v;
      void'($urandom(93));
      {arst_n, wb_cyc, wb_stb, wb_we, key_press} = '0;
      {wb_adr, wb_sel, wb_dat_w} = '0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      meas_len(len);
      chk_len(len, exp_len(1, 1, 1));
      lo = 0;
      while (done_n === 1'b0 && lo < 100) begin
         @(posedge core_clk);
         lo++;
      end
      chk_len(lo, 1);
      meas_len(len);
      chk_len(len, exp_len(1, 1, 1));
      wb_xfer(1'b1, ADDR_CTRL, ctrl_word(2'd1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00));
      wait_idle();
      $display("test internal done");
      for (int i = 0; i < 8; i++) begin
         wb_xfer(1'b1, ADDR_CTRL, ctrl_word(2'd1, 1'b0, i[0], i[1], i[2], 8'h00));
         sv = starts;
         r0 = rng_c;
         a0 = ana_c;
         c0 = cmp_c;
         fork
            key_twice();
            meas_len(len);
         join
         chk_len(len, exp_len(i[2], i[0], i[1]));
         wait_idle();
         chk_len(starts - sv, 1);
         chk_len(rng_c - r0, i[2] ? RNG : 0);
         chk_len(ana_c - a0, ANA);
         chk_len(cmp_c - c0, (i[0] ? C_ON : C_OFF) - (i[1] ? 0 : C_DS));
         disc_exp++;
      end
      $display("test key done");
      for (int i = 0; i < 5; i++) begin
         wb_xfer(1'b1, ADDR_CTRL, ctrl_word(2'd2, i >= 2, 1'b1, 1'b1, 1'b0, 8'h00));
         sv = starts;
         if (i == 4) HM.handler_pulse(2);
         else HM.rear_level(i == 0 || i == 2);
         wait_idle();
         chk_len(starts - sv, (i == 1 || i == 2) ? 0 : 1);
      end
      $display("test external done");
      wb_xfer(1'b1, ADDR_CTRL, ctrl_word(2'd3, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00));
      for (int k = 1; k <= 2; k++) begin
         sv = starts;
         repeat (k) wb_xfer(1'b1, ADDR_CMD, 32'h0000_0001);
         wait_idle();
         chk_len(starts - sv, 1);
         disc_exp = disc_exp + k - 1;
      end
      // idle status: every started cycle completed, dropped triggers counted
      wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk_reg(rd, {16'(starts), 8'(disc_exp), 8'h00});
      wb_xfer(1'b0, ADDR_CMD, 32'h0000_0000);
      chk_reg(rd, 32'h0000_0000);
      wb_xfer(1'b0, 8'h10, 32'h0000_0000);
      chk_reg(rd, 32'h0000_0000);
      $display("test bus done");
      for (int k = 0; k < 8; k++) begin
         v = (k < 4) ? tbl[k] : 8'($urandom);
         wb_xfer(1'b1, ADDR_CTRL, ctrl_word(2'd1, 1'b0, 1'b1, 1'b1, 1'b1, v));
         ex = $signed(v);
         ex = (ex > 2) ? 2 : ((ex < -2) ? -2 : ex);
         wb_xfer(1'b0, ADDR_CTRL, 32'h0000_0000);
         chk_reg(rd & 32'h0000_FF3F, ctrl_word(2'd1, 1'b0, 1'b1, 1'b1, 1'b1, 8'(ex)));
         chk_reg({24'h0, shift_pct}, {24'h0, 8'(ex)});
      end
      $display("test shift done");
      end_sim();
   end
endmodule : tb_measurement_trigger_control
